// ### hdl/ces_top.sv
// Exception sequencer: source priority, reset fetch, stacking, vectoring.
`timescale 1ns/1ps
module ces_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CHIP_CLEAR_N,
  input wire logic NMI_LEVEL,
  input wire logic DECODE_VALID,
  input wire logic INSTR_DONE,
  input wire logic UNDEF_OP,
  input wire logic PC_WRITE_OP,
  input wire logic IN_DELAY_SLOT,
  input wire logic TRAP_EXEC,
  input wire logic [ces_pkg::TRAP_SEL_W-1:0] TRAP_SEL,
  input wire logic ADDR_ERR_CPU,
  input wire logic ADDR_ERR_DMA,
  input wire logic INT_REQ,
  input wire logic [7:0] INT_VECTOR,
  input wire logic [3:0] INT_LEVEL,
  input wire logic [31:0] STATUS_WORD_IN,
  input wire logic [31:0] RETURN_POINTER_IN,
  input wire logic [31:0] STACK_REG_IN,
  input wire logic [31:0] TABLE_BASE_POINTER_IN,
  output logic BUSY,
  output logic ACCEPT,
  output logic [7:0] ACCEPT_VECTOR,
  output logic INT_ACK,
  output logic POINTER_LOAD,
  output logic [31:0] POINTER_OUT,
  output logic STACK_LOAD,
  output logic [31:0] STACK_OUT,
  output logic MASK_LOAD,
  output logic [3:0] MASK_OUT,
  output logic TABLE_BASE_CLEAR,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Table entry address: base plus vector number times word size.
  function automatic logic [31:0] vec_addr(input logic [31:0] base,
                                           input logic [7:0] vec);
    vec_addr = base + 32'(vec) * ces_pkg::WORD_BYTES;
  endfunction : vec_addr

  ces_mem_if m ();

  ces_bus_port u_port (
    .CLK(CLK),
    .RESET(RESET),
    .m(m.port),
    .mem_req(MEM_REQ),
    .mem_we(MEM_WE),
    .mem_addr(MEM_ADDR),
    .mem_wdata(MEM_WDATA),
    .mem_ack(MEM_ACK),
    .mem_rdata(MEM_RDATA)
  );

  ces_pkg::ces_state_t state_ff, nxt_state;
  logic go_ff, nxt_go;
  logic we_ff, nxt_we;
  logic [31:0] addr_ff, nxt_addr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic pin_prev_ff, nxt_pin_prev;
  logic ae_cpu_ff, nxt_ae_cpu;
  logic ae_dma_ff, nxt_ae_dma;
  logic int_pend_ff, nxt_int_pend;
  logic [7:0] int_vec_ff, nxt_int_vec;
  logic [3:0] int_lvl_ff, nxt_int_lvl;
  logic armed_ff, nxt_armed;
  logic is_int_ff, nxt_is_int;
  logic [3:0] lvl_ff, nxt_lvl;
  logic [7:0] vec_ff, nxt_vec;
  logic [31:0] sp_ff, nxt_sp;
  logic [31:0] pc_save_ff, nxt_pc_save;
  logic [31:0] newpc_ff, nxt_newpc;
  logic busy_ff, nxt_busy;
  logic accept_ff, nxt_accept;
  logic int_ack_ff, nxt_int_ack;
  logic pc_load_ff, nxt_pc_load;
  logic [31:0] pc_out_ff, nxt_pc_out;
  logic sp_load_ff, nxt_sp_load;
  logic [31:0] sp_out_ff, nxt_sp_out;
  logic mask_load_ff, nxt_mask_load;
  logic [3:0] mask_out_ff, nxt_mask_out;
  logic base_clear_ff, nxt_base_clear;
  logic pin_rise;
  logic mem_done;
  logic ae_ready;
  logic int_ready;

  assign pin_rise = CHIP_CLEAR_N & ~pin_prev_ff;
  // A done seen while a request is still unclaimed is a stale
  // completion of a cycle started before a chip clear.
  assign mem_done = m.done & ~go_ff;
  assign ae_ready = armed_ff & INSTR_DONE & (ae_cpu_ff | ae_dma_ff);
  assign int_ready = armed_ff & INSTR_DONE & int_pend_ff;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_go = go_ff & ~m.taken;
    nxt_we = we_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_pin_prev = CHIP_CLEAR_N;
    nxt_ae_cpu = ae_cpu_ff;
    nxt_ae_dma = ae_dma_ff;
    nxt_int_pend = int_pend_ff;
    nxt_int_vec = int_vec_ff;
    nxt_int_lvl = int_lvl_ff;
    nxt_armed = armed_ff;
    nxt_is_int = is_int_ff;
    nxt_lvl = lvl_ff;
    nxt_vec = vec_ff;
    nxt_sp = sp_ff;
    nxt_pc_save = pc_save_ff;
    nxt_newpc = newpc_ff;
    nxt_accept = 1'b0;
    nxt_int_ack = 1'b0;
    nxt_pc_load = 1'b0;
    nxt_pc_out = pc_out_ff;
    nxt_sp_load = 1'b0;
    nxt_sp_out = sp_out_ff;
    nxt_mask_load = 1'b0;
    nxt_mask_out = mask_out_ff;
    nxt_base_clear = 1'b0;
    case (state_ff)
      ces_pkg::ST_IDLE: begin
        // Highest ready source wins, one at a time.
        if (pin_rise) begin
          nxt_state = ces_pkg::ST_RST_PC;
        end else if (ae_ready) begin
          // Fixed vectors for the two error sources.
          nxt_vec = ae_cpu_ff ? ces_pkg::VEC_CPU_AE : ces_pkg::VEC_DMA_AE;
          nxt_is_int = 1'b0;
          nxt_state = ces_pkg::ST_PUSH_SR;
          if (ae_cpu_ff) begin
            nxt_ae_cpu = 1'b0;
          end else begin
            nxt_ae_dma = 1'b0;
          end
        end else if (int_ready) begin
          // Interrupt vectors come from the controller.
          nxt_vec = int_vec_ff;
          nxt_lvl = int_lvl_ff;
          nxt_is_int = 1'b1;
          nxt_int_pend = 1'b0;
          nxt_int_ack = 1'b1;
          nxt_state = ces_pkg::ST_PUSH_SR;
        end else if (!armed_ff && TRAP_EXEC) begin
          // Trap vector chosen by the trap operand.
          // Traps sit at vectors from 32 upward.
          nxt_vec = ces_pkg::VEC_TRAP_BASE | 8'(TRAP_SEL);
          nxt_is_int = 1'b0;
          nxt_state = ces_pkg::ST_PUSH_SR;
        end else if (!armed_ff && DECODE_VALID && IN_DELAY_SLOT &&
                     (UNDEF_OP || PC_WRITE_OP)) begin
          // Slot faults take the slot vector.
          nxt_vec = ces_pkg::VEC_SLOT;
          nxt_is_int = 1'b0;
          nxt_state = ces_pkg::ST_PUSH_SR;
        end else if (!armed_ff && DECODE_VALID && UNDEF_OP) begin
          nxt_vec = ces_pkg::VEC_ILLEGAL;
          nxt_is_int = 1'b0;
          nxt_state = ces_pkg::ST_PUSH_SR;
        end
        if (nxt_state == ces_pkg::ST_PUSH_SR) begin
          nxt_accept = 1'b1;
          nxt_armed = 1'b0;
          nxt_sp = STACK_REG_IN - ces_pkg::WORD_BYTES;
          nxt_addr = STACK_REG_IN - ces_pkg::WORD_BYTES;
          nxt_wdata = STATUS_WORD_IN;
          nxt_pc_save = RETURN_POINTER_IN;
          nxt_we = 1'b1;
          nxt_go = 1'b1;
        end
      end
      ces_pkg::ST_RST_PC: begin
        if (mem_done) begin
          // Entries are start pointer, then stack top.
          nxt_newpc = m.rdata;
          nxt_addr = addr_ff + ces_pkg::WORD_BYTES;
          nxt_go = 1'b1;
          nxt_state = ces_pkg::ST_RST_SP;
        end
      end
      ces_pkg::ST_RST_SP: begin
        if (mem_done) begin
          // Clear base, set mask, start at fetched pointer.
          nxt_pc_load = 1'b1;
          nxt_pc_out = newpc_ff;
          nxt_sp_load = 1'b1;
          nxt_sp_out = m.rdata;
          nxt_base_clear = 1'b1;
          nxt_mask_load = 1'b1;
          nxt_mask_out = ces_pkg::MASK_ALL;
          nxt_state = ces_pkg::ST_IDLE;
        end
      end
      ces_pkg::ST_PUSH_SR: begin
        if (mem_done) begin
          // Second word pushed is the return pointer.
          nxt_sp = sp_ff - ces_pkg::WORD_BYTES;
          nxt_addr = sp_ff - ces_pkg::WORD_BYTES;
          nxt_wdata = pc_save_ff;
          nxt_go = 1'b1;
          nxt_state = ces_pkg::ST_PUSH_PC;
        end
      end
      ces_pkg::ST_PUSH_PC: begin
        if (mem_done) begin
          // Non-reset entries are offset by the table base.
          nxt_addr = vec_addr(TABLE_BASE_POINTER_IN, vec_ff);
          nxt_we = 1'b0;
          nxt_go = 1'b1;
          nxt_state = ces_pkg::ST_FETCH;
        end
      end
      ces_pkg::ST_FETCH: begin
        if (mem_done) begin
          // Jump to the fetched handler address.
          nxt_pc_load = 1'b1;
          nxt_pc_out = m.rdata;
          nxt_sp_load = 1'b1;
          nxt_sp_out = sp_ff;
          // Interrupts load their own level into the mask; others keep it.
          // Other exceptions leave the mask alone.
          nxt_mask_load = is_int_ff;
          nxt_mask_out = is_int_ff ? lvl_ff : mask_out_ff;
          nxt_state = ces_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = ces_pkg::ST_IDLE;
      end
    endcase
    // Address errors latch in any cycle but a clear wins over them; interrupts latch at decode when none is pending.
    if (ADDR_ERR_CPU) begin
      nxt_ae_cpu = 1'b1;
    end
    if (ADDR_ERR_DMA) begin
      nxt_ae_dma = 1'b1;
    end
    if (DECODE_VALID && INT_REQ && !int_pend_ff && !nxt_int_ack) begin
      nxt_int_pend = 1'b1;
      nxt_int_vec = INT_VECTOR;
      nxt_int_lvl = INT_LEVEL;
    end
    // An arm needs a source that is still pending after this cycle.
    if (DECODE_VALID && ((ae_cpu_ff && nxt_ae_cpu) ||
        (ae_dma_ff && nxt_ae_dma) || (int_pend_ff && nxt_int_pend))) begin
      nxt_armed = 1'b1;
    end
    if (!CHIP_CLEAR_N || pin_rise) begin
      nxt_ae_cpu = 1'b0;
      nxt_ae_dma = 1'b0;
      nxt_int_pend = 1'b0;
      nxt_armed = 1'b0;
      nxt_go = 1'b0;
      nxt_state = ces_pkg::ST_IDLE;
      nxt_accept = 1'b0;
      nxt_int_ack = 1'b0;
      nxt_pc_load = 1'b0;
      nxt_sp_load = 1'b0;
      nxt_mask_load = 1'b0;
      nxt_base_clear = 1'b0;
    end
    if (pin_rise) begin
      // Request pin high selects the power-on entries.
      // Request pin low selects the manual entries.
      nxt_vec = NMI_LEVEL ? ces_pkg::VEC_POR_PC : ces_pkg::VEC_MAN_PC;
      // Reset entries are absolute, from address zero.
      // Manual entries follow at bytes eight and twelve.
      nxt_addr = vec_addr(ces_pkg::TABLE_BASE_RST, nxt_vec);
      nxt_we = 1'b0;
      nxt_go = 1'b1;
      nxt_accept = 1'b1;
      nxt_state = ces_pkg::ST_RST_PC;
    end
    nxt_busy = (nxt_state != ces_pkg::ST_IDLE) | ~CHIP_CLEAR_N;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_ff <= ces_pkg::ST_IDLE;
      go_ff <= 1'b0;
      we_ff <= 1'b0;
      addr_ff <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      pin_prev_ff <= 1'b1;
      ae_cpu_ff <= 1'b0;
      ae_dma_ff <= 1'b0;
      int_pend_ff <= 1'b0;
      int_vec_ff <= 8'h00;
      int_lvl_ff <= 4'h0;
      armed_ff <= 1'b0;
      is_int_ff <= 1'b0;
      lvl_ff <= 4'h0;
      vec_ff <= 8'h00;
      sp_ff <= 32'h0000_0000;
      pc_save_ff <= 32'h0000_0000;
      newpc_ff <= 32'h0000_0000;
      busy_ff <= 1'b0;
      accept_ff <= 1'b0;
      int_ack_ff <= 1'b0;
      pc_load_ff <= 1'b0;
      pc_out_ff <= 32'h0000_0000;
      sp_load_ff <= 1'b0;
      sp_out_ff <= 32'h0000_0000;
      mask_load_ff <= 1'b0;
      mask_out_ff <= ces_pkg::MASK_ALL;
      base_clear_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      go_ff <= nxt_go;
      we_ff <= nxt_we;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      pin_prev_ff <= nxt_pin_prev;
      ae_cpu_ff <= nxt_ae_cpu;
      ae_dma_ff <= nxt_ae_dma;
      int_pend_ff <= nxt_int_pend;
      int_vec_ff <= nxt_int_vec;
      int_lvl_ff <= nxt_int_lvl;
      armed_ff <= nxt_armed;
      is_int_ff <= nxt_is_int;
      lvl_ff <= nxt_lvl;
      vec_ff <= nxt_vec;
      sp_ff <= nxt_sp;
      pc_save_ff <= nxt_pc_save;
      newpc_ff <= nxt_newpc;
      busy_ff <= nxt_busy;
      accept_ff <= nxt_accept;
      int_ack_ff <= nxt_int_ack;
      pc_load_ff <= nxt_pc_load;
      pc_out_ff <= nxt_pc_out;
      sp_load_ff <= nxt_sp_load;
      sp_out_ff <= nxt_sp_out;
      mask_load_ff <= nxt_mask_load;
      mask_out_ff <= nxt_mask_out;
      base_clear_ff <= nxt_base_clear;
    end
  end

  assign m.req = go_ff;
  assign m.we = we_ff;
  assign m.addr = addr_ff;
  assign m.wdata = wdata_ff;
  assign BUSY = busy_ff;
  assign ACCEPT = accept_ff;
  assign ACCEPT_VECTOR = vec_ff;
  assign INT_ACK = int_ack_ff;
  assign POINTER_LOAD = pc_load_ff;
  assign POINTER_OUT = pc_out_ff;
  assign STACK_LOAD = sp_load_ff;
  assign STACK_OUT = sp_out_ff;
  assign MASK_LOAD = mask_load_ff;
  assign MASK_OUT = mask_out_ff;
  assign TABLE_BASE_CLEAR = base_clear_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_sr_pushed;
    CHIP_CLEAR_N && state_ff == ces_pkg::ST_PUSH_SR && mem_done;
  endsequence

  sequence s_pc_word;
    state_ff == ces_pkg::ST_PUSH_PC && we_ff && go_ff &&
      wdata_ff == pc_save_ff;
  endsequence

  chk_single_accept: assert property (
    accept_ff |-> $past(state_ff) == ces_pkg::ST_IDLE ||
      $past(pin_rise))
    else $error("Exception accepted while another was running.");
  chk_por_start: assert property (
    pin_rise && NMI_LEVEL |=> accept_ff && vec_ff == ces_pkg::VEC_POR_PC
      && addr_ff == 32'h0000_0000 ##1 state_ff == ces_pkg::ST_RST_PC)
    else $error("Power-on reset did not start.");
  chk_manual_start: assert property (
    pin_rise && !NMI_LEVEL |=> accept_ff &&
      vec_ff == ces_pkg::VEC_MAN_PC)
    else $error("Manual reset did not start.");
  chk_ae_waits: assert property (
    accept_ff && (vec_ff == ces_pkg::VEC_CPU_AE ||
      vec_ff == ces_pkg::VEC_DMA_AE) |-> $past(INSTR_DONE))
    else $error("Address error started before instruction end.");
  chk_illegal_vec: assert property (
    accept_ff && vec_ff == ces_pkg::VEC_ILLEGAL |->
      !$past(IN_DELAY_SLOT) && $past(UNDEF_OP))
    else $error("General illegal vector taken in a slot.");
  chk_reset_tail: assert property (
    CHIP_CLEAR_N && state_ff == ces_pkg::ST_RST_SP && mem_done |=>
      pc_load_ff &&
      base_clear_ff && mask_load_ff && mask_out_ff == ces_pkg::MASK_ALL)
    else $error("Reset fetch did not finish properly.");
  chk_push_order: assert property (
    s_sr_pushed |=> s_pc_word ##0 addr_ff == $past(sp_ff) - 32'h4)
    else $error("Second stacked word wrong.");
  chk_mask_kept: assert property (
    mask_load_ff && !base_clear_ff |-> $past(is_int_ff) &&
      mask_out_ff == $past(lvl_ff))
    else $error("Mask changed for a non-interrupt exception.");
  chk_fetch_addr: assert property (
    CHIP_CLEAR_N && state_ff == ces_pkg::ST_PUSH_PC && mem_done |=>
      !we_ff &&
      addr_ff == $past(TABLE_BASE_POINTER_IN) + 32'(vec_ff) * 32'h4)
    else $error("Handler fetch address wrong.");
  chk_no_reserved: assert property (
    accept_ff |-> vec_ff != ces_pkg::VEC_RSVD_A &&
      vec_ff != ces_pkg::VEC_RSVD_B && vec_ff != ces_pkg::VEC_RSVD_C &&
      !(vec_ff >= ces_pkg::VEC_RSVD_LO && vec_ff <= ces_pkg::VEC_RSVD_HI))
    else $error("Reserved vector used.");

endmodule : ces_top

// ### hdl/ces_pkg.sv
// Shared constants and types of the CPU exception sequencer.
package ces_pkg;

  // ----------------------------------------------------------------
  // Vector numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_POR_PC = 8'h00;
  localparam logic [7:0] VEC_MAN_PC = 8'h02;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_RSVD_A = 8'h05;
  localparam logic [7:0] VEC_SLOT = 8'h06;
  localparam logic [7:0] VEC_RSVD_B = 8'h07;
  localparam logic [7:0] VEC_RSVD_C = 8'h08;
  localparam logic [7:0] VEC_CPU_AE = 8'h09;
  localparam logic [7:0] VEC_DMA_AE = 8'h0a;
  localparam logic [7:0] VEC_NMI = 8'h0b;
  localparam logic [7:0] VEC_UBREAK = 8'h0c;
  localparam logic [7:0] VEC_RSVD_LO = 8'h0d;
  localparam logic [7:0] VEC_RSVD_HI = 8'h1f;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
  localparam logic [7:0] VEC_EXT_BASE = 8'h40;
  localparam logic [7:0] VEC_ONCHIP_LO = 8'h48;

  // ----------------------------------------------------------------
  // Widths and values after reset
  // ----------------------------------------------------------------
  localparam int TRAP_SEL_W = 5;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] TABLE_BASE_RST = 32'h0000_0000;
  localparam logic [3:0] MASK_ALL = 4'hf;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_RST_PC  = 6'h02,
    ST_RST_SP  = 6'h04,
    ST_PUSH_SR = 6'h08,
    ST_PUSH_PC = 6'h10,
    ST_FETCH   = 6'h20
  } ces_state_t;

endpackage : ces_pkg

// ### hdl/ces_mem_if.sv
// Word request channel between the sequencer and its memory bus port.
`timescale 1ns/1ps
interface ces_mem_if;
  logic req;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic taken;
  logic done;
  logic [31:0] rdata;

  modport seq (output req, we, addr, wdata, input taken, done, rdata);
  modport port (input req, we, addr, wdata, output taken, done, rdata);
endinterface : ces_mem_if

// ### hdl/ces_bus_port.sv
// Memory bus port that runs one word access at a time for the sequencer.
`timescale 1ns/1ps
module ces_bus_port (
  input wire logic CLK,
  input wire logic RESET,
  ces_mem_if.port m,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);

  logic req_ff, nxt_req;
  logic we_ff, nxt_we;
  logic [31:0] addr_ff, nxt_addr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic taken_ff, nxt_taken;
  logic done_ff, nxt_done;
  logic [31:0] rdata_ff, nxt_rdata;

  // ----------------------------------------------------------------
  // Access control
  // ----------------------------------------------------------------
  // A started cycle always runs to its acknowledge, even across a
  // chip clear, so a bus cycle is never cut short.
  always_comb begin
    nxt_req = req_ff;
    nxt_we = we_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_taken = 1'b0;
    nxt_done = 1'b0;
    nxt_rdata = rdata_ff;
    if (!req_ff && m.req) begin
      nxt_req = 1'b1;
      nxt_we = m.we;
      nxt_addr = m.addr;
      nxt_wdata = m.wdata;
      nxt_taken = 1'b1;
    end else if (req_ff && mem_ack) begin
      nxt_req = 1'b0;
      nxt_done = 1'b1;
      nxt_rdata = mem_rdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      addr_ff <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      taken_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      req_ff <= nxt_req;
      we_ff <= nxt_we;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      taken_ff <= nxt_taken;
      done_ff <= nxt_done;
      rdata_ff <= nxt_rdata;
    end
  end

  assign m.taken = taken_ff;
  assign m.done = done_ff;
  assign m.rdata = rdata_ff;
  assign mem_req = req_ff;
  assign mem_we = we_ff;
  assign mem_addr = addr_ff;
  assign mem_wdata = wdata_ff;

endmodule : ces_bus_port

// ### tb/ces_mem_model.sv
// Memory bus model answering the sequencer's word accesses.
`timescale 1ns/1ps
module ces_mem_model (
  input wire logic clk,
  input wire logic req,
  input wire logic [31:0] addr,
  input wire logic [3:0] wait_cyc,
  output logic ack,
  output logic [31:0] rdata
);
  logic [3:0] cnt;
  initial begin
    ack = 1'h0;
    rdata = 32'h0;
    cnt = 4'h0;
  end
  always @(negedge clk) begin
    if (req && !ack && cnt == wait_cyc) begin
      ack = 1'h1;
      rdata = addr ^ 32'h5a5a_0000;
    end else begin
      ack = 1'h0;
      rdata = ~rdata;
    end
    cnt = (req && !ack) ? cnt + 4'h1 : 4'h0;
  end
endmodule : ces_mem_model

// ### tb/tb_ces_top.sv
// Self-checking bench for the exception sequencer.
`timescale 1ns/1ps
module tb_ces_top;
  localparam logic [31:0] K = 32'h5a5a_0000;
  logic CLK = 1'h0, RESET = 1'h1, CHIP_CLEAR_N = 1'h1, NMI_LEVEL = 1'h1;
  logic DECODE_VALID = 1'h0, INSTR_DONE = 1'h1, UNDEF_OP = 1'h0;
  logic PC_WRITE_OP = 1'h0, IN_DELAY_SLOT = 1'h0, TRAP_EXEC = 1'h0;
  logic [4:0] TRAP_SEL = 5'h00;
  logic ADDR_ERR_CPU = 1'h0, ADDR_ERR_DMA = 1'h0, INT_REQ = 1'h0;
  logic [7:0] INT_VECTOR = 8'h40;
  logic [3:0] INT_LEVEL = 4'h1, wait_cyc = 4'h0;
  logic [31:0] STATUS_WORD_IN = 32'h0000_00f0;
  logic [31:0] RETURN_POINTER_IN = 32'h0000_1234;
  logic [31:0] STACK_REG_IN = 32'h0000_8000;
  logic [31:0] TABLE_BASE_POINTER_IN = 32'h0000_0400;
  logic BUSY, ACCEPT, INT_ACK, POINTER_LOAD, STACK_LOAD, MASK_LOAD;
  logic TABLE_BASE_CLEAR, MEM_REQ, MEM_WE, MEM_ACK;
  logic [7:0] ACCEPT_VECTOR;
  logic [3:0] MASK_OUT;
  logic [31:0] POINTER_OUT, STACK_OUT, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic [64:0] log_q[$];
  logic mask_seen, tbc_seen;
  int mismatches = 0, comparisons = 0;

  ces_top ces_top_inst (.CLK(CLK), .RESET(RESET),
    .CHIP_CLEAR_N(CHIP_CLEAR_N), .NMI_LEVEL(NMI_LEVEL),
    .DECODE_VALID(DECODE_VALID), .INSTR_DONE(INSTR_DONE),
    .UNDEF_OP(UNDEF_OP), .PC_WRITE_OP(PC_WRITE_OP),
    .IN_DELAY_SLOT(IN_DELAY_SLOT), .TRAP_EXEC(TRAP_EXEC),
    .TRAP_SEL(TRAP_SEL), .ADDR_ERR_CPU(ADDR_ERR_CPU),
    .ADDR_ERR_DMA(ADDR_ERR_DMA), .INT_REQ(INT_REQ),
    .INT_VECTOR(INT_VECTOR), .INT_LEVEL(INT_LEVEL),
    .STATUS_WORD_IN(STATUS_WORD_IN), .RETURN_POINTER_IN(RETURN_POINTER_IN),
    .STACK_REG_IN(STACK_REG_IN),
    .TABLE_BASE_POINTER_IN(TABLE_BASE_POINTER_IN), .BUSY(BUSY),
    .ACCEPT(ACCEPT), .ACCEPT_VECTOR(ACCEPT_VECTOR), .INT_ACK(INT_ACK),
    .POINTER_LOAD(POINTER_LOAD), .POINTER_OUT(POINTER_OUT),
    .STACK_LOAD(STACK_LOAD), .STACK_OUT(STACK_OUT),
    .MASK_LOAD(MASK_LOAD), .MASK_OUT(MASK_OUT),
    .TABLE_BASE_CLEAR(TABLE_BASE_CLEAR), .MEM_REQ(MEM_REQ),
    .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));
  ces_mem_model ces_mem_model_inst (.clk(CLK), .req(MEM_REQ),
    .addr(MEM_ADDR), .wait_cyc(wait_cyc), .ack(MEM_ACK),
    .rdata(MEM_RDATA));

  initial forever #25 CLK = ~CLK;
  initial begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    end_of_test();
  end
  always @(posedge CLK) begin
    if (MEM_REQ && MEM_ACK)
      log_q.push_back({MEM_WE, MEM_ADDR, MEM_WE ? MEM_WDATA : 32'h0});
    if (MASK_LOAD) mask_seen <= 1'h1;
    if (TABLE_BASE_CLEAR) tbc_seen <= 1'h1;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string nm, input logic [64:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp

  task automatic run(input logic [7:0] vec, input logic rst,
                     input logic [3:0] lvl);
    logic [31:0] va;
    logic irq;
    int n;
    irq = lvl != 4'h0 && !rst;
    va = {22'h0, vec, 2'h0} + (rst ? 32'h0 : TABLE_BASE_POINTER_IN);
    log_q.delete();
    for (n = 0; n < 40 && ACCEPT !== 1'h1; n++) @(negedge CLK);
    // Pulses of the previous sequence may still land in the flags.
    mask_seen = 1'h0;
    tbc_seen = 1'h0;
    cmp("accept", ACCEPT, 1'h1);
    cmp("vector", ACCEPT_VECTOR, vec);
    cmp("int ack", INT_ACK, irq);
    if (INT_ACK === 1'h1) INT_REQ = 1'h0;
    if (vec inside {[8'h04:8'h06], [8'h20:8'h3f]})
      {TRAP_EXEC, DECODE_VALID, UNDEF_OP, PC_WRITE_OP} = 4'h0;
    for (n = 0; n < 80 && POINTER_LOAD !== 1'h1; n++) @(negedge CLK);
    cmp("busy end", BUSY, 1'h0);
    cmp("stack load", STACK_LOAD, 1'h1);
    cmp("pointer", POINTER_OUT, va ^ K);
    cmp("base clear", TABLE_BASE_CLEAR | tbc_seen, rst);
    cmp("mask load", MASK_LOAD | mask_seen, rst | irq);
    if (rst | irq) cmp("mask", MASK_OUT, rst ? 4'hf : lvl);
    cmp("mem count", log_q.size(), rst ? 2 : 3);
    if (rst) begin
      cmp("rd pointer", log_q[0], {1'h0, va, 32'h0});
      cmp("rd stack", log_q[1], {1'h0, va + 32'h4, 32'h0});
      cmp("stack", STACK_OUT, (va + 32'h4) ^ K);
    end else begin
      cmp("push sr", log_q[0], {1'h1, STACK_REG_IN - 32'h4,
          STATUS_WORD_IN});
      cmp("push pc", log_q[1], {1'h1, STACK_REG_IN - 32'h8,
          RETURN_POINTER_IN});
      cmp("rd vector", log_q[2], {1'h0, va, 32'h0});
      cmp("stack", STACK_OUT, STACK_REG_IN - 32'h8);
    end
  endtask : run

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic pin_reset(input logic nmi, input logic [7:0] vec);
    CHIP_CLEAR_N = 1'h0;
    NMI_LEVEL = nmi;
    repeat (3) @(negedge CLK);
    cmp("busy", BUSY, 1'h1);
    CHIP_CLEAR_N = 1'h1;
    run(vec, 1'h1, 4'hf);
  endtask : pin_reset

  task automatic trap_case();
    TRAP_SEL = 5'h1f;
    TRAP_EXEC = 1'h1;
    run(8'h3f, 1'h0, 4'h0);
  endtask : trap_case

  task automatic decode_case(input logic slot, pcw, undef,
                             input logic [7:0] vec);
    {IN_DELAY_SLOT, PC_WRITE_OP, UNDEF_OP} = {slot, pcw, undef};
    DECODE_VALID = 1'h1;
    run(vec, 1'h0, 4'h0);
  endtask : decode_case

  task automatic prio_case();
    IN_DELAY_SLOT = 1'h0;
    INSTR_DONE = 1'h0;
    INT_VECTOR = 8'h41;
    INT_LEVEL = 4'h3;
    {ADDR_ERR_CPU, ADDR_ERR_DMA, INT_REQ, DECODE_VALID} = 4'hf;
    @(negedge CLK);
    {ADDR_ERR_CPU, ADDR_ERR_DMA} = 2'h0;
    @(negedge CLK);
    // Decoding goes on, so the sources still pending stay armed.
    TRAP_SEL = 5'h00;
    TRAP_EXEC = 1'h1;
    repeat (4) begin
      @(negedge CLK);
      cmp("early accept", ACCEPT, 1'h0);
    end
    INSTR_DONE = 1'h1;
    run(8'h09, 1'h0, 4'h0);
    run(8'h0a, 1'h0, 4'h0);
    run(8'h41, 1'h0, 4'h3);
    run(8'h20, 1'h0, 4'h0);
  endtask : prio_case

  task automatic end_of_test();
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (12) @(negedge CLK);
    RESET = 1'h0;
    @(negedge CLK);
    pin_reset(1'h1, 8'h00);
    wait_cyc = 4'h3;
    pin_reset(1'h0, 8'h02);
    trap_case();
    wait_cyc = 4'h0;
    decode_case(1'h0, 1'h0, 1'h1, 8'h04);
    decode_case(1'h1, 1'h0, 1'h1, 8'h06);
    decode_case(1'h1, 1'h1, 1'h0, 8'h06);
    prio_case();
    end_of_test();
  end
endmodule : tb_ces_top
